// ---- common/ocal_pkg.sv ----
// What this block does
// - With RC selected, calibration alters the 64 Hz divider stage by the RC offset
// - Negative offset swallows 64 Hz cycles; positive adds 128 Hz pulses
// - Range 00: offset applied per 8,192 s period, 1.907 ppm a step
// - Range 01: offset applied per 4,096 s period, 3.82 ppm a step
// - Range 10: offset applied per 2,048 s period, 7.64 ppm a step
// - Range 11: offset applied per 1,024 s period, 15.28 ppm a step
// - RC offset is two's complement, -8,192 to +8,191
// - Steps spread evenly; at most one 64 Hz period of jitter
// - Autocal counts crystal cycles over RC-timed window, loads RC calibration
// - Select 0: run on crystal with good supply, calibrate RC periodically
// - Supply loss with auto-switch: RC clocks, crystal and autocal off
// - Select 1: always clock from RC, crystal on only for autocal
// - Interval 00 off, 01 reserved, 10 every 1024 s, 11 every 512 s
// - RC mode autocal keeps crystal on about 50 s
// - Interval leaving 00 starts one autocal run at once
// - Over 12.5% off: set fail flag, leave RC calibration unchanged
// - Crystal offset applied per 32 s, or 16 s in coarse mode
// - Crystal extended slowdown is 122 ppm per unit
package ocal_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RC_CAL = 8'h04;
	localparam logic [7:0] REG_XT_CAL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	// Field positions
	localparam int CTRL_OSC_SOURCE_SELECT = 0;
	localparam int CTRL_AOS = 1;
	localparam int CTRL_IVAL = 2;
	localparam int CTRL_IRQEN = 4;
	localparam int RC_OFF = 0;
	localparam int RC_RNG = 16;
	localparam int XT_OFF = 0;
	localparam int XT_COARSE = 7;
	localparam int XT_EXT = 8;
	localparam int ST_FAIL = 0;
	localparam int ST_RCACT = 1;
	localparam int ST_XTEN = 2;
	localparam int ST_BUSY = 3;
	localparam int ST_SUPLOW = 4;
	// Reset values
	localparam logic RST_OSC_SOURCE_SELECT = 1'h0;
	localparam logic RST_AOS = 1'h0;
	localparam logic [1:0] RST_IVAL = 2'h0;
	localparam logic [13:0] RST_RC_OFF = 14'h0000;
	localparam logic [1:0] RST_RC_RNG = 2'h0;
	// Interval codes
	localparam logic [1:0] IVAL_OFF = 2'h0;
	localparam logic [1:0] IVAL_RSVD = 2'h1;
	localparam logic [1:0] IVAL_1024 = 2'h2;
	localparam logic [1:0] IVAL_512 = 2'h3;
	// Times in seconds, rates in Hz
	localparam int IVAL_LONG_SEC = 1024;
	localparam int IVAL_SHORT_SEC = 512;
	localparam int XT_ON_SEC = 50;
	localparam int MEAS_SEC = 2;
	localparam int WARM_SEC = XT_ON_SEC - MEAS_SEC;
	localparam int RC_HZ = 128;
	localparam int XT_CAL_HZ = 16384;
	localparam int MEAS_RC_TICKS = MEAS_SEC * RC_HZ;
	localparam int XT_NOMINAL = MEAS_SEC * XT_CAL_HZ;
	// One step is 2^-19; period is 2^19 slow cycles at range 0
	localparam int CAL_PERIOD_LOG2 = 19;
	localparam int STEP_SHIFT = 4;
	localparam int XT_EXT_SHIFT = 6;
	localparam int RNG1_LIM = 8192;
	localparam int RNG2_LIM = 16384;
	localparam int RNG3_LIM = 32768;
	localparam int FAIL_LIM = 65536;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WARM = 3'h2,
		ST_MEAS = 3'h4
	} ocal_state_e;
endpackage : ocal_pkg

// ---- core/ocal_spread.sv ----
`timescale 1ns/10ps
`default_nettype none
module ocal_spread #(
	parameter int OW = 14
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Source and settings
	input wire logic fast_tick,
	input wire logic [OW-1:0] offset,
	input wire logic [1:0] range,
	// Calibrated half-rate output and period-end pulse
	output logic slow_tick,
	output logic period_end
);
	localparam int PW = ocal_pkg::CAL_PERIOD_LOG2;
	typedef struct packed {
		logic phase;
		logic pend;
		logic tick;
		logic pend_end;
		logic [PW-1:0] acc;
		logic [PW-1:0] cnt;
		logic [OW-1:0] sh_off;
		logic [1:0] sh_rng;
	} ocal_spread_s;
	ocal_spread_s s;
	ocal_spread_s next_s;
	logic [OW-1:0] mag;
	logic [PW:0] sum;
	logic [PW-1:0] last;
	logic adj;
	logic neg;

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		next_s.pend_end = 1'b0;
		neg = s.sh_off[OW-1];
		mag = neg ? OW'(-s.sh_off) : s.sh_off;
		sum = {1'b0, s.acc} + ((PW+1)'(mag) << s.sh_rng);
		adj = sum[PW];
		last = {PW{1'b1}} >> s.sh_rng;
		if (fast_tick) begin
			if (!s.phase) begin
				next_s.phase = 1'b1;
				// extra pulse fills the first half
				next_s.tick = s.pend;
				next_s.pend = 1'b0;
			end else begin
				next_s.phase = 1'b0;
				next_s.acc = sum[PW-1:0];
				// gate or queue an extra pulse
				next_s.tick = !(adj && neg);
				next_s.pend = adj && !neg;
				if (s.cnt == last) begin
					next_s.cnt = {PW{1'b0}};
					next_s.acc = {PW{1'b0}};
					next_s.sh_off = offset;
					next_s.sh_rng = range;
					next_s.pend_end = 1'b1;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign slow_tick = s.tick;
	assign period_end = s.pend_end;

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_tick_cause: assert property (
		$rose(slow_tick) |-> $past(fast_tick) && $past(ce)
	) else $error("slow tick without a source tick");
	a_shadow_hold: assert property (
		!$stable(s.sh_off) || !$stable(s.sh_rng) |-> period_end
	) else $error("settings changed inside a period");
	a_pos_extra: assert property (
		ce && fast_tick && !s.phase && s.pend |=> slow_tick
	) else $error("queued positive pulse lost");
endmodule : ocal_spread
`default_nettype wire

// ---- core/ocal_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module ocal_top #(
	// 64 Hz ticks per second; shorten in simulation
	parameter int SEC_TICKS = 64
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Oscillators and supply
	input wire logic rc_tick,
	input wire logic xt_tick,
	input wire logic supply_low,
	// Clock control outputs
	output logic xtal_enable,
	output logic rc_active,
	output logic tick_64hz,
	output logic xt_tick_16k,
	output logic autocal_fail_irq
);
	typedef struct packed {
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic osc_source_select;
		logic auto_switch_on_supply_loss;
		logic [1:0] ival;
		logic irq_en;
		logic [13:0] rc_off;
		logic [1:0] rc_rng;
		logic [6:0] xt_off;
		logic xt_coarse;
		logic [1:0] xt_ext;
		logic fail;
		ocal_pkg::ocal_state_e st;
		logic [1:0] prev_ival;
		logic [5:0] sub;
		logic [9:0] sec;
		logic [5:0] warm;
		logic [7:0] rc_cnt;
		logic [16:0] xt_cnt;
		logic [7:0] xt_div;
		logic rc_act;
		logic xt_en;
		logic tick64;
	} ocal_s;

	localparam logic [5:0] SUB_LAST = 6'(SEC_TICKS - 1);
	localparam logic [5:0] WARM_LAST = 6'(ocal_pkg::WARM_SEC - 1);
	localparam logic [7:0] RC_LAST = 8'(ocal_pkg::MEAS_RC_TICKS - 1);
	localparam logic [9:0] LONG_LAST = 10'(ocal_pkg::IVAL_LONG_SEC - 1);
	localparam logic [9:0] SHORT_LAST = 10'(ocal_pkg::IVAL_SHORT_SEC - 1);
	localparam logic signed [21:0] LIM1 = 22'(ocal_pkg::RNG1_LIM);
	localparam logic signed [21:0] LIM2 = 22'(ocal_pkg::RNG2_LIM);
	localparam logic signed [21:0] LIM3 = 22'(ocal_pkg::RNG3_LIM);
	localparam logic signed [21:0] LIMF = 22'(ocal_pkg::FAIL_LIM);

	// One-hot register select; zero when unmapped
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		reg_sel = {a == ocal_pkg::REG_STATUS, a == ocal_pkg::REG_XT_CAL,
			a == ocal_pkg::REG_RC_CAL, a == ocal_pkg::REG_CTRL};
	endfunction : reg_sel

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[8*i +: 8] = wd[8*i +: 8];
			end
		end
	endfunction : merge

	logic [1:0] rst_sync;
	logic rst_s;
	ocal_s s;
	ocal_s next_s;
	logic rc64;
	logic xt16;
	logic [9:0] xt_eff;
	logic halt;
	logic rc_now;
	logic sec_hit;
	logic ival_on;
	logic armed;
	logic periodic;
	logic start;
	logic finish;
	logic [9:0] ival_last;
	logic signed [17:0] diff;
	logic signed [21:0] adj;
	logic signed [21:0] adj_sh;
	logic fail_c;
	logic [1:0] rng_c;
	logic xt64;
	logic write_go;
	logic [3:0] wsel;
	logic [3:0] rsel;
	logic [31:0] ctrl_img;
	logic [31:0] rc_img;
	logic [31:0] xt_img;
	logic [31:0] st_img;
	logic [31:0] wv;

	// Reset released through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_s = rst_sync[1];

	assign xt_eff = {{3{s.xt_off[6]}}, s.xt_off}
		- 10'({s.xt_ext, 6'h00} >> s.xt_coarse);

	ocal_spread #(.OW(14)) u_rc_cal (
		.clk(clk),
		.rst_n(rst_s),
		.ce(ce),
		.fast_tick(rc_tick),
		.offset(s.rc_off),
		.range(s.rc_rng),
		.slow_tick(rc64),
		.period_end()
	);

	ocal_spread #(.OW(10)) u_xt_cal (
		.clk(clk),
		.rst_n(rst_s),
		.ce(ce),
		.fast_tick(xt_tick && s.xt_en),
		.offset(xt_eff),
		.range({1'b0, s.xt_coarse}),
		.slow_tick(xt16),
		.period_end()
	);

	always_comb begin
		ctrl_img = 32'h0000_0000;
		ctrl_img[ocal_pkg::CTRL_OSC_SOURCE_SELECT] = s.osc_source_select;
		ctrl_img[ocal_pkg::CTRL_AOS] = s.auto_switch_on_supply_loss;
		ctrl_img[ocal_pkg::CTRL_IVAL +: 2] = s.ival;
		ctrl_img[ocal_pkg::CTRL_IRQEN] = s.irq_en;
		rc_img = 32'h0000_0000;
		rc_img[ocal_pkg::RC_OFF +: 14] = s.rc_off;
		rc_img[ocal_pkg::RC_RNG +: 2] = s.rc_rng;
		xt_img = 32'h0000_0000;
		xt_img[ocal_pkg::XT_OFF +: 7] = s.xt_off;
		xt_img[ocal_pkg::XT_COARSE] = s.xt_coarse;
		xt_img[ocal_pkg::XT_EXT +: 2] = s.xt_ext;
		st_img = 32'h0000_0000;
		st_img[ocal_pkg::ST_FAIL] = s.fail;
		st_img[ocal_pkg::ST_RCACT] = s.rc_act;
		st_img[ocal_pkg::ST_XTEN] = s.xt_en;
		st_img[ocal_pkg::ST_BUSY] = s.st != ocal_pkg::ST_IDLE;
		st_img[ocal_pkg::ST_SUPLOW] = supply_low;
	end

	always_comb begin
		next_s = s;
		next_s.tick64 = 1'b0;
		// supply loss with auto-switch forces RC and stops the crystal
		halt = s.auto_switch_on_supply_loss && supply_low;
		// select bit picks the running source
		rc_now = s.osc_source_select || halt;
		sec_hit = rc64 && (s.sub == SUB_LAST);
		if (rc64) begin
			next_s.sub = sec_hit ? 6'h00 : s.sub + 1'b1;
		end
		// only 10 and 11 run periodically
		ival_on = s.ival[1];
		ival_last = (s.ival == ocal_pkg::IVAL_512) ? SHORT_LAST : LONG_LAST;
		periodic = ival_on && sec_hit && (s.sec == ival_last);
		if (halt || !ival_on) begin
			next_s.sec = 10'h000;
		end else if (sec_hit) begin
			next_s.sec = (s.sec == ival_last) ? 10'h000 : s.sec + 1'b1;
		end
		armed = (s.prev_ival == ocal_pkg::IVAL_OFF)
			&& (s.ival != ocal_pkg::IVAL_OFF);
		next_s.prev_ival = s.ival;
		start = (armed || periodic) && !halt;

		diff = 18'({1'b0, s.xt_cnt}) - 18'(ocal_pkg::XT_NOMINAL);
		adj = 22'(diff) <<< ocal_pkg::STEP_SHIFT;
		fail_c = (adj < -LIMF) || (adj >= LIMF);
		if (adj >= -LIM1 && adj < LIM1) begin
			rng_c = 2'h0;
		end else if (adj >= -LIM2 && adj < LIM2) begin
			rng_c = 2'h1;
		end else if (adj >= -LIM3 && adj < LIM3) begin
			rng_c = 2'h2;
		end else begin
			rng_c = 2'h3;
		end
		adj_sh = adj >>> rng_c;
		finish = 1'b0;

		unique case (s.st)
			ocal_pkg::ST_IDLE: begin
				if (start) begin
					next_s.warm = 6'h00;
					next_s.rc_cnt = 8'h00;
					next_s.xt_cnt = 17'h00000;
					// RC mode warms the crystal first
					next_s.st = s.osc_source_select ? ocal_pkg::ST_WARM : ocal_pkg::ST_MEAS;
				end
			end
			ocal_pkg::ST_WARM: begin
				if (sec_hit) begin
					if (s.warm == WARM_LAST) begin
						next_s.st = ocal_pkg::ST_MEAS;
					end else begin
						next_s.warm = s.warm + 1'b1;
					end
				end
			end
			ocal_pkg::ST_MEAS: begin
				if (xt16 && s.xt_cnt != 17'h1FFFF) begin
					next_s.xt_cnt = s.xt_cnt + 1'b1;
				end
				if (rc_tick) begin
					if (s.rc_cnt == RC_LAST) begin
						finish = 1'b1;
						next_s.st = ocal_pkg::ST_IDLE;
					end else begin
						next_s.rc_cnt = s.rc_cnt + 1'b1;
					end
				end
			end
			default: begin
				next_s.st = ocal_pkg::ST_IDLE;
			end
		endcase
		if (halt) begin
			next_s.st = ocal_pkg::ST_IDLE;
			finish = 1'b0;
		end

		if (xt16) begin
			next_s.xt_div = s.xt_div + 1'b1;
		end
		xt64 = xt16 && (s.xt_div == 8'hFF);
		// timekeeping stays on RC during warm-up
		next_s.tick64 = rc_now ? rc64 : xt64;
		next_s.rc_act = rc_now;
		// in RC mode, crystal powered only while a run is busy
		next_s.xt_en = !rc_now || (next_s.st != ocal_pkg::ST_IDLE);

		// Bus write path; address and data in either order
		write_go = s.aw_have && s.w_have && !s.bvalid;
		wsel = reg_sel(s.aw_addr);
		wv = 32'h0000_0000;
		if (s_axi_awvalid && !s.aw_have) begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_have) begin
			next_s.w_have = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (write_go) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = (|wsel) ? ocal_pkg::RESP_OKAY
				: ocal_pkg::RESP_SLVERR;
			if (wsel[0]) begin
				wv = merge(ctrl_img, s.w_data, s.w_strb);
				next_s.osc_source_select = wv[ocal_pkg::CTRL_OSC_SOURCE_SELECT];
				next_s.auto_switch_on_supply_loss = wv[ocal_pkg::CTRL_AOS];
				next_s.ival = wv[ocal_pkg::CTRL_IVAL +: 2];
				next_s.irq_en = wv[ocal_pkg::CTRL_IRQEN];
			end
			if (wsel[1]) begin
				wv = merge(rc_img, s.w_data, s.w_strb);
				next_s.rc_off = wv[ocal_pkg::RC_OFF +: 14];
				next_s.rc_rng = wv[ocal_pkg::RC_RNG +: 2];
			end
			if (wsel[2]) begin
				wv = merge(xt_img, s.w_data, s.w_strb);
				next_s.xt_off = wv[ocal_pkg::XT_OFF +: 7];
				next_s.xt_coarse = wv[ocal_pkg::XT_COARSE];
				next_s.xt_ext = wv[ocal_pkg::XT_EXT +: 2];
			end
			// Fail flag clears on writing one
			if (wsel[3] && s.w_strb[0] && s.w_data[ocal_pkg::ST_FAIL]) begin
				next_s.fail = 1'b0;
			end
		end

		// Hardware results override a same-cycle software write
		if (finish) begin
			if (fail_c) begin
				next_s.fail = 1'b1;
			end else begin
				next_s.rc_rng = rng_c;
				next_s.rc_off = adj_sh[13:0];
			end
		end

		// Bus read path
		rsel = reg_sel(s_axi_araddr);
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s.rvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = (|rsel) ? ocal_pkg::RESP_OKAY
				: ocal_pkg::RESP_SLVERR;
			next_s.rdata = ({32{rsel[0]}} & ctrl_img)
				| ({32{rsel[1]}} & rc_img)
				| ({32{rsel[2]}} & xt_img)
				| ({32{rsel[3]}} & st_img);
		end
	end

	always_ff @(posedge clk or negedge rst_s) begin
		if (!rst_s) begin
			s <= '0;
			s.osc_source_select <= ocal_pkg::RST_OSC_SOURCE_SELECT;
			s.auto_switch_on_supply_loss <= ocal_pkg::RST_AOS;
			s.ival <= ocal_pkg::RST_IVAL;
			s.prev_ival <= ocal_pkg::RST_IVAL;
			s.rc_off <= ocal_pkg::RST_RC_OFF;
			s.rc_rng <= ocal_pkg::RST_RC_RNG;
			s.st <= ocal_pkg::ST_IDLE;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign s_axi_awready = ce && !s.aw_have;
	assign s_axi_wready = ce && !s.w_have;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = ce && !s.rvalid;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign xtal_enable = s.xt_en;
	assign rc_active = s.rc_act;
	assign tick_64hz = s.tick64;
	assign xt_tick_16k = xt16;
	assign autocal_fail_irq = s.fail && s.irq_en;

	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_s);
	a_fail_keeps_cal: assert property (
		ce && finish && fail_c |=> s.fail && $stable(s.rc_off)
			&& $stable(s.rc_rng)
	) else $error("failed run altered RC calibration");
	a_halt_xt_off: assert property (
		ce && halt |=> !xtal_enable && rc_active
			&& s.st == ocal_pkg::ST_IDLE
	) else $error("crystal or run alive on supply loss");
	a_rc_xt_run: assert property (
		rc_active && xtal_enable |-> s.st != ocal_pkg::ST_IDLE
	) else $error("crystal on in RC mode outside a run");
	a_tick_source: assert property (
		ce && rc_now && rc64 ##1 ce |-> tick_64hz
			##1 (!ce || !tick_64hz || rc64)
	) else $error("RC timekeeping tick dropped");
	a_ival_start: assert property (
		ce && armed && !halt && s.st == ocal_pkg::ST_IDLE
			|=> s.st != ocal_pkg::ST_IDLE
	) else $error("interval change did not start a run");
	a_meas_end: assert property (
		ce && s.st == ocal_pkg::ST_MEAS && rc_tick && s.rc_cnt == RC_LAST
			&& !halt && !fail_c |=> s.st == ocal_pkg::ST_IDLE
			&& s.rc_rng == $past(rng_c)
	) else $error("measurement end did not load calibration");
	c_fail_seen: cover property (ce && finish && fail_c);
	c_cal_loaded: cover property (ce && finish && !fail_c);
	c_warm_run: cover property (s.st == ocal_pkg::ST_WARM && sec_hit);
endmodule : ocal_top
`default_nettype wire

// ---- dv/test_ocal_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("BAD t=%0t got %h exp %h", $time, got, exp); \
	end \
end
module test_ocal_top;
	logic clk;
	logic rst_n;
	logic ce;
	logic [7:0] awaddr;
	logic [7:0] araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic rc_tick, xt_tick, supply_low;
	logic xtal_enable, rc_active, tick_64hz, fail_irq, xt16k;
	int mismatches = 0;
	int compares = 0;
	int ticks = 0;
	logic [31:0] d;
	logic [1:0] r;

	// One simulated second is one calibrated 64 Hz tick
	ocal_top #(.SEC_TICKS(1)) u_dut (
		.clk(clk), .rst_n(rst_n), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rc_tick(rc_tick), .xt_tick(xt_tick),
		.supply_low(supply_low), .xtal_enable(xtal_enable),
		.rc_active(rc_active), .tick_64hz(tick_64hz),
		.xt_tick_16k(xt16k), .autocal_fail_irq(fail_irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Crystal only oscillates while powered
	always @(posedge clk)
		xt_tick <= xtal_enable ? ~xt_tick : 1'b0;

	always @(posedge clk)
		if (tick_64hz === 1'b1) ticks++;

	task automatic wr(input logic [7:0] a, input logic [31:0] dat,
			input logic [3:0] s, output logic [1:0] resp);
		logic aw_on;
		logic w_on;
		aw_on = 1'b1;
		w_on = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= dat;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_on || w_on) begin
			@(posedge clk);
			if (aw_on && awready === 1'b1) begin
				aw_on = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_on && wready === 1'b1) begin
				w_on = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] dat,
			output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		dat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	// Pulses spaced well above the two-cycle minimum
	task automatic rc_run(input int n);
		for (int i = 0; i < n; i++) begin
			rc_tick <= 1'b1;
			@(posedge clk);
			rc_tick <= 1'b0;
			repeat (7) @(posedge clk);
		end
	endtask : rc_run

	task automatic close_out;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	// Whole run is about 3300 cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		close_out();
	end

	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		rc_tick = 1'b0;
		supply_low = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);

		rd(ocal_pkg::REG_CTRL, d, r);
		`CHK(d, 32'h0000_0000)
		rd(ocal_pkg::REG_RC_CAL, d, r);
		`CHK(d, 32'h0000_0000)
		rd(ocal_pkg::REG_XT_CAL, d, r);
		`CHK(d, 32'h0000_0000)
		$display("reset values done");

		wr(ocal_pkg::REG_RC_CAL, 32'hFFFF_FFFF, 4'hF, r);
		`CHK(r, ocal_pkg::RESP_OKAY)
		rd(ocal_pkg::REG_RC_CAL, d, r);
		`CHK(d, 32'h0003_3FFF)
		wr(ocal_pkg::REG_RC_CAL, 32'h0000_0000, 4'h1, r);
		rd(ocal_pkg::REG_RC_CAL, d, r);
		`CHK(d, 32'h0003_3F00)
		// Host clears RC calibration before measuring
		wr(ocal_pkg::REG_RC_CAL, 32'h0000_0000, 4'hF, r);
		rd(ocal_pkg::REG_RC_CAL, d, r);
		`CHK(d, 32'h0000_0000)
		wr(ocal_pkg::REG_XT_CAL, 32'hFFFF_FFFF, 4'hF, r);
		rd(ocal_pkg::REG_XT_CAL, d, r);
		`CHK(d, 32'h0000_03FF)
		// Host result for -300 steps: slowdown 3, coarse, offset -54
		wr(ocal_pkg::REG_XT_CAL, 32'h0000_03CA, 4'hF, r);
		rd(ocal_pkg::REG_XT_CAL, d, r);
		`CHK(d, 32'h0000_03CA)
		// Host result for 16383 steps: range 1, offset 8191
		wr(ocal_pkg::REG_RC_CAL, 32'h0001_1FFF, 4'hF, r);
		wr(8'h10, 32'h1234_5678, 4'hF, r);
		`CHK(r, ocal_pkg::RESP_SLVERR)
		rd(8'h10, d, r);
		`CHK(r, ocal_pkg::RESP_SLVERR)
		`CHK(d, 32'h0000_0000)
		$display("register access done");

		// Auto-switch on supply loss, then recovery
		wr(ocal_pkg::REG_CTRL, 32'h0000_0002, 4'hF, r);
		supply_low <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(rc_active, 1'b1)
		`CHK(xtal_enable, 1'b0)
		rd(ocal_pkg::REG_STATUS, d, r);
		`CHK(d, 32'h0000_0012)
		supply_low <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(rc_active, 1'b0)
		`CHK(xtal_enable, 1'b1)
		$display("supply switchover done");

		// RC mode run; slow crystal forces an out-of-range result
		wr(ocal_pkg::REG_CTRL, 32'h0000_0011, 4'hF, r);
		repeat (2) @(posedge clk);
		`CHK(rc_active, 1'b1)
		`CHK(xtal_enable, 1'b0)
		wr(ocal_pkg::REG_CTRL, 32'h0000_0019, 4'hF, r);
		repeat (2) @(posedge clk);
		`CHK(xtal_enable, 1'b1)
		rd(ocal_pkg::REG_STATUS, d, r);
		`CHK(d, 32'h0000_000E)
		ticks = 0;
		rc_run(90);
		`CHK(xtal_enable, 1'b1)
		`CHK(rc_active, 1'b1)
		rc_run(310);
		`CHK(ticks, 200)
		`CHK(xtal_enable, 1'b0)
		`CHK(xt16k, 1'b0)
		`CHK(fail_irq, 1'b1)
		rd(ocal_pkg::REG_STATUS, d, r);
		`CHK(d, 32'h0000_0003)
		rd(ocal_pkg::REG_RC_CAL, d, r);
		`CHK(d, 32'h0001_1FFF)
		wr(ocal_pkg::REG_STATUS, 32'h0000_0001, 4'h1, r);
		rd(ocal_pkg::REG_STATUS, d, r);
		`CHK(d, 32'h0000_0002)
		`CHK(fail_irq, 1'b0)
		$display("autocalibration run done");

		// Enable low freezes the divider chain
		ticks = 0;
		ce <= 1'b0;
		rc_run(4);
		ce <= 1'b1;
		`CHK(ticks, 0)
		$display("clock enable done");
		close_out();
	end
endmodule : test_ocal_top
`default_nettype wire
